// ---- ascd_pkg.sv ----
/*
 * Shared constants and carrier types of the serial command decoder.
 * Assumes one system clock that also serves as the converter master clock.
 */
`default_nettype none
package ascd_pkg;
	localparam int NUM_REGS = 11;
	localparam logic [4:0] LAST_ADDR = 5'h0A;
	localparam int OFC_BASE = 5;
	localparam int FSC_BASE = 8;
	// addresses 0Ah down to 00h; the id nibble is merged in on read
	localparam logic [10:0][7:0] REG_RESET = {8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h03, 8'h32, 8'h08, 8'h52, 8'h00};
	// opcodes; wake, standby, sync and reset compared on bits 7:1 (bit 0 don't care), register read/write on bits 7:5
	localparam logic [6:0] OPC_WAKE_HI = 7'h00;
	localparam logic [6:0] OPC_STANDBY_HI = 7'h01;
	localparam logic [6:0] OPC_SYNC_HI = 7'h02;
	localparam logic [6:0] OPC_RESET_HI = 7'h03;
	localparam logic [7:0] OPC_CONT_READ = 8'h10;
	localparam logic [7:0] OPC_STOP_CONT = 8'h11;
	localparam logic [7:0] OPC_READ_DATA = 8'h12;
	localparam logic [2:0] OPC_REG_READ_HI = 3'h1;
	localparam logic [2:0] OPC_REG_WRITE_HI = 3'h2;
	localparam logic [7:0] OPC_OFFSET_CAL = 8'h60;
	localparam logic [7:0] OPC_GAIN_CAL = 8'h61;
	// inter_byte_gap in master clock cycles, clock_in is the master clock
	localparam logic [7:0] INTER_BYTE_GAP_CYC = 8'h18;
	localparam logic [5:0] SETTLE_READINGS = 6'h3F;

	typedef enum logic [2:0] {PH_CMD, PH_RD_CNT, PH_RD_DATA, PH_WR_CNT, PH_WR_DATA} ascd_phase_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} ascd_conv_t;

	typedef struct packed {
		logic done;
		logic [23:0] value;
	} ascd_cal_t;

	typedef struct packed {
		logic standby;
		logic cont_mode;
		logic restart;
		logic offset_cal_start;
		logic gain_cal_start;
		logic gap_error;
	} ascd_ctrl_t;

	typedef struct packed {
		logic sclk_s1, sclk_s2, sclk_s3;
		logic din_s1, din_s2;
		logic mode_s1, mode_s2;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		ascd_phase_t phase;
		logic [4:0] addr;
		logic [4:0] remain;
		logic [31:0] shift_out;
		logic load_pend;
		logic [7:0] load_byte;
		logic cont_mode;
		logic standby;
		logic rdata_pend;
		logic result_ready_n_n;
		logic [5:0] settle;
		logic [7:0] gap_cnt;
		logic gap_err;
		logic cal_gain;
		logic restart;
		logic ofs_start;
		logic gain_start;
		logic [10:0][7:0] regs;
	} ascd_state_t;
endpackage : ascd_pkg
`default_nettype wire

// ---- ascd_decoder.sv ----
/*
 * Serial command decoder of a delta-sigma converter: byte framing on the
 * host serial clock, command decode, register file, result readout.
 * Assumes the filter core delivers results and calibration values on
 * clock_in; sclk, din and the mode pin come from outside and are synchronised.
 */
// Notes on behaviour
// - commands act only in register control mode; ignored in pin mode
// - continuous mode shifts results out on host clock without commands
// - 0000000X leaves standby and resumes conversions
// - leave-standby outside standby changes nothing
// - 0000001X enters standby; registers and serial port stay alive
// - 0000010X abandons current conversion and restarts
// - 0000011X restores defaults, enables continuous read, restarts
// - 10h enables continuous read; ready falls for each new result
// - 11h leaves continuous read and suppresses ready; conversions continue
// - 12h outputs the next result once
// - register read: start address byte then count-minus-one byte
// - read data appears from the 16th falling clock edge, address increments
// - register write: start address byte then count-minus-one byte
// - write takes exactly count data bytes for consecutive addresses; bytes for 00h and past 0Ah are not stored
// - 60h starts offset calibration; result lands in offset_correction
// - 61h starts gain calibration; result lands in gain_correction
// - any register write restarts conversion, dropping 63 readings
// - registers 00h to 0Ah, reached by read and write commands; calibration results and 0000011X also load them
`timescale 1ns/1ps
`default_nettype none
module ascd_decoder #(
	parameter logic [3:0] ID_CODE = 4'h5 // arbitrary value
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// serial pins
	input wire logic sclk_in,
	input wire logic din_in,
	input wire logic reg_mode_in,
	output logic dout_out,
	output logic result_ready_n_out,
	// converter core
	input wire ascd_pkg::ascd_conv_t conv_in,
	input wire ascd_pkg::ascd_cal_t cal_in,
	output ascd_pkg::ascd_ctrl_t ctrl_out,
	output logic [10:0][7:0] regs_out
);
	ascd_pkg::ascd_state_t st_r;
	ascd_pkg::ascd_state_t st_nxt;
	logic rise;
	logic fall;
	logic byte_done;
	logic [7:0] rx_byte;
	logic take;
	logic conv_take;

	function automatic logic [7:0] reg_read(input logic [10:0][7:0] regs,
		input logic [4:0] addr);
		logic [7:0] v;
		v = 8'h00;
		if (addr == 5'h00) begin
			v = {ID_CODE, 4'h0};
		end else if (addr <= ascd_pkg::LAST_ADDR) begin
			v = regs[addr[3:0]];
		end
		return v;
	endfunction : reg_read

	assign rise = st_r.sclk_s2 & ~st_r.sclk_s3;
	assign fall = ~st_r.sclk_s2 & st_r.sclk_s3;
	assign byte_done = rise && (st_r.bit_cnt == 3'h7);
	assign rx_byte = {st_r.shift_in[6:0], st_r.din_s2};
	assign take = byte_done && st_r.mode_s2;
	assign conv_take = conv_in.valid && !st_r.standby && (st_r.settle == 6'h00);

	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_s1 = sclk_in;
		st_nxt.sclk_s2 = st_r.sclk_s1;
		st_nxt.sclk_s3 = st_r.sclk_s2;
		st_nxt.din_s1 = din_in;
		st_nxt.din_s2 = st_r.din_s1;
		st_nxt.mode_s1 = reg_mode_in;
		st_nxt.mode_s2 = st_r.mode_s1;
		st_nxt.restart = 1'b0;
		st_nxt.ofs_start = 1'b0;
		st_nxt.gain_start = 1'b0;
		if (st_r.gap_cnt != 8'hFF) begin
			st_nxt.gap_cnt = st_r.gap_cnt + 8'h01;
		end
		if (rise) begin
			st_nxt.shift_in = rx_byte;
			st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
			st_nxt.result_ready_n_n = 1'b1;
			// sticky until reset: a short gap may have corrupted framing
			if (st_r.bit_cnt == 3'h0 && st_r.gap_cnt < ascd_pkg::INTER_BYTE_GAP_CYC) begin
				st_nxt.gap_err = 1'b1;
			end
		end
		if (byte_done) begin
			st_nxt.gap_cnt = 8'h00;
		end
		if (fall) begin
			if (st_r.load_pend) begin
				st_nxt.shift_out = {st_r.load_byte, 24'h000000};
				st_nxt.load_pend = 1'b0;
			end else begin
				st_nxt.shift_out = {st_r.shift_out[30:0], 1'b0};
			end
		end
		if (conv_in.valid && !st_r.standby) begin
			if (st_r.settle != 6'h00) begin
				st_nxt.settle = st_r.settle - 6'h01;
			end else if (st_r.cont_mode || st_r.rdata_pend) begin
				st_nxt.shift_out = conv_in.data;
				st_nxt.result_ready_n_n = 1'b0;
				st_nxt.rdata_pend = 1'b0;
			end
		end
		if (cal_in.done) begin
			if (st_r.cal_gain) begin
				st_nxt.regs[ascd_pkg::FSC_BASE +: 3] = cal_in.value;
			end else begin
				st_nxt.regs[ascd_pkg::OFC_BASE +: 3] = cal_in.value;
			end
		end
		if (take) begin
			case (st_r.phase)
				ascd_pkg::PH_CMD: begin
					if (rx_byte[7:1] == ascd_pkg::OPC_WAKE_HI) begin
						st_nxt.standby = 1'b0;
					end else if (rx_byte[7:1] == ascd_pkg::OPC_STANDBY_HI) begin
						st_nxt.standby = 1'b1;
						st_nxt.result_ready_n_n = 1'b1;
					end else if (rx_byte[7:1] == ascd_pkg::OPC_SYNC_HI) begin
						st_nxt.restart = 1'b1;
						st_nxt.result_ready_n_n = 1'b1;
					end else if (rx_byte[7:1] == ascd_pkg::OPC_RESET_HI) begin
						st_nxt.regs = ascd_pkg::REG_RESET;
						st_nxt.cont_mode = 1'b1;
						st_nxt.standby = 1'b0;
						st_nxt.rdata_pend = 1'b0;
						st_nxt.settle = 6'h00;
						st_nxt.restart = 1'b1;
						st_nxt.result_ready_n_n = 1'b1;
					end else if (rx_byte == ascd_pkg::OPC_CONT_READ) begin
						st_nxt.cont_mode = 1'b1;
					end else if (rx_byte == ascd_pkg::OPC_STOP_CONT) begin
						st_nxt.cont_mode = 1'b0;
						st_nxt.result_ready_n_n = 1'b1;
					end else if (rx_byte == ascd_pkg::OPC_READ_DATA) begin
						st_nxt.rdata_pend = 1'b1;
					end else if (rx_byte == ascd_pkg::OPC_OFFSET_CAL) begin
						st_nxt.ofs_start = 1'b1;
						st_nxt.cal_gain = 1'b0;
					end else if (rx_byte == ascd_pkg::OPC_GAIN_CAL) begin
						st_nxt.gain_start = 1'b1;
						st_nxt.cal_gain = 1'b1;
					end else if (rx_byte[7:5] == ascd_pkg::OPC_REG_READ_HI) begin
						st_nxt.addr = rx_byte[4:0];
						st_nxt.phase = ascd_pkg::PH_RD_CNT;
					end else if (rx_byte[7:5] == ascd_pkg::OPC_REG_WRITE_HI) begin
						st_nxt.addr = rx_byte[4:0];
						st_nxt.phase = ascd_pkg::PH_WR_CNT;
					end
					// any other byte falls through untouched
				end
				ascd_pkg::PH_RD_CNT: begin
					st_nxt.remain = rx_byte[4:0];
					st_nxt.load_byte = reg_read(st_r.regs, st_r.addr);
					st_nxt.load_pend = 1'b1;
					st_nxt.phase = ascd_pkg::PH_RD_DATA;
				end
				ascd_pkg::PH_RD_DATA: begin
					if (st_r.remain == 5'h00) begin
						st_nxt.phase = ascd_pkg::PH_CMD;
					end else begin
						st_nxt.addr = st_r.addr + 5'h01;
						st_nxt.remain = st_r.remain - 5'h01;
						st_nxt.load_byte = reg_read(st_r.regs, st_r.addr + 5'h01);
						st_nxt.load_pend = 1'b1;
					end
				end
				ascd_pkg::PH_WR_CNT: begin
					st_nxt.remain = rx_byte[4:0];
					st_nxt.phase = ascd_pkg::PH_WR_DATA;
				end
				default: begin
					// id and addresses past the map are not writable
					if (st_r.addr != 5'h00 && st_r.addr <= ascd_pkg::LAST_ADDR) begin
						st_nxt.regs[st_r.addr[3:0]] = rx_byte;
					end
					st_nxt.addr = st_r.addr + 5'h01;
					st_nxt.remain = st_r.remain - 5'h01;
					if (st_r.remain == 5'h00) begin
						st_nxt.phase = ascd_pkg::PH_CMD;
						st_nxt.restart = 1'b1;
						st_nxt.settle = ascd_pkg::SETTLE_READINGS;
						st_nxt.result_ready_n_n = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
			st_r.regs <= ascd_pkg::REG_RESET;
			st_r.cont_mode <= 1'b1;
			st_r.result_ready_n_n <= 1'b1;
			st_r.gap_cnt <= ascd_pkg::INTER_BYTE_GAP_CYC;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout_out = st_r.shift_out[31];
	assign result_ready_n_out = st_r.result_ready_n_n;
	assign regs_out = st_r.regs;
	assign ctrl_out = '{standby: st_r.standby, cont_mode: st_r.cont_mode,
		restart: st_r.restart, offset_cal_start: st_r.ofs_start,
		gain_cal_start: st_r.gain_start, gap_error: st_r.gap_err};

	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	a_pin_mode_ignore: assert property (
		byte_done && !st_r.mode_s2 |=> $stable(st_r.phase) && $stable(st_r.standby)
			&& $stable(st_r.cont_mode)) else $error("command taken in pin mode");
	a_standby_enter: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:1] == ascd_pkg::OPC_STANDBY_HI
		|=> ctrl_out.standby && result_ready_n_out) else $error("standby not entered");
	a_wake_exit: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:1] == ascd_pkg::OPC_WAKE_HI
		|=> !ctrl_out.standby) else $error("standby not left");
	a_wake_no_effect: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:1] == ascd_pkg::OPC_WAKE_HI
		&& !st_r.standby && !conv_in.valid
		|=> $stable(result_ready_n_out) && $stable(st_r.shift_out))
		else $error("wake disturbed output");
	a_sync_restart: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:1] == ascd_pkg::OPC_SYNC_HI
		|=> ctrl_out.restart ##1 !ctrl_out.restart) else $error("restart pulse wrong");
	a_reset_defaults: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:1] == ascd_pkg::OPC_RESET_HI
		&& !cal_in.done |=> regs_out == ascd_pkg::REG_RESET && ctrl_out.cont_mode
		&& ctrl_out.restart) else $error("reset command incomplete");
	a_stop_cont_quiet: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte == ascd_pkg::OPC_STOP_CONT
		##1 (!conv_in.valid && !st_r.rdata_pend)[*2] |-> result_ready_n_out)
		else $error("ready shown after stop");
	a_result_ready: assert property (
		conv_take && st_r.cont_mode && !take |=> !result_ready_n_out
		&& dout_out == $past(conv_in.data[31])) else $error("result not presented");
	a_read_first_byte: assert property (
		take && st_r.phase == ascd_pkg::PH_RD_CNT ##[1:40] (fall && !conv_take)
		|=> st_r.shift_out[31:24] == reg_read(st_r.regs, st_r.addr))
		else $error("register byte not on dout");
	a_write_settle: assert property (
		take && st_r.phase == ascd_pkg::PH_WR_DATA && st_r.remain == 5'h00
		|=> st_r.settle == ascd_pkg::SETTLE_READINGS && ctrl_out.restart
		&& st_r.phase == ascd_pkg::PH_CMD) else $error("write did not restart");
	a_data_arm: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte == ascd_pkg::OPC_READ_DATA
		|=> st_r.rdata_pend) else $error("single read not armed");
	a_single_once: assert property (
		conv_take && st_r.rdata_pend && !st_r.cont_mode && !take
		|=> !result_ready_n_out && !st_r.rdata_pend) else $error("single read not served");
	a_cont_enable: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte == ascd_pkg::OPC_CONT_READ
		|=> ctrl_out.cont_mode) else $error("continuous read not enabled");
	a_stop_cont_mode: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte == ascd_pkg::OPC_STOP_CONT
		|=> !ctrl_out.cont_mode && result_ready_n_out) else $error("continuous read not left");
	a_read_start: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:5] == ascd_pkg::OPC_REG_READ_HI
		|=> st_r.phase == ascd_pkg::PH_RD_CNT && st_r.addr == $past(rx_byte[4:0]))
		else $error("read start not taken");
	a_write_start: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:5] == ascd_pkg::OPC_REG_WRITE_HI
		|=> st_r.phase == ascd_pkg::PH_WR_CNT && st_r.addr == $past(rx_byte[4:0]))
		else $error("write start not taken");
	a_write_stores: assert property (
		take && st_r.phase == ascd_pkg::PH_WR_DATA && st_r.addr != 5'h00
		&& st_r.addr <= ascd_pkg::LAST_ADDR
		|=> regs_out[$past(st_r.addr[3:0])] == $past(rx_byte)) else $error("write byte lost");
	a_offset_start: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte == ascd_pkg::OPC_OFFSET_CAL
		|=> ctrl_out.offset_cal_start ##1 !ctrl_out.offset_cal_start)
		else $error("offset cal not started");
	a_offset_store: assert property (
		cal_in.done && !st_r.cal_gain && !take
		|=> regs_out[ascd_pkg::OFC_BASE +: 3] == $past(cal_in.value)) else $error("offset lost");
	a_gain_store: assert property (
		cal_in.done && st_r.cal_gain && !take
		|=> regs_out[ascd_pkg::FSC_BASE +: 3] == $past(cal_in.value)) else $error("gain lost");
	a_unknown_ignored: assert property (
		take && st_r.phase == ascd_pkg::PH_CMD && rx_byte[7:5] == 3'h3 && rx_byte[4:1] != 4'h0
		&& !cal_in.done |=> $stable(st_r.cont_mode) && $stable(st_r.standby)
		&& $stable(st_r.phase) && $stable(regs_out)) else $error("undefined opcode acted");
	a_standby_regs: assert property (
		st_r.standby && !take && !cal_in.done
		|=> $stable(regs_out)) else $error("standby lost registers");
endmodule : ascd_decoder
`default_nettype wire

// ---- ascd_host_model.sv ----
/* host serial master model: drives sclk and din, samples dout.
   assumes the device samples din on sclk rise and shifts dout on fall. */
`timescale 1ns/1ps
`default_nettype none
module ascd_host_model (
	// serial pins
	output logic sclk_out,
	output logic din_out,
	input wire logic dout_in
);
	initial begin
		sclk_out = 1'b0;
		din_out = 1'b0;
	end
	// one byte each way, msb first; sclk stands low between bytes
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			// 60/65 split keeps both edges off the rising clock when a byte starts on a fall
			din_out = tx[i];
			#60 sclk_out = 1'b1;
			rx[i] = dout_in;
			#65 sclk_out = 1'b0;
		end
		// released data line shows the inverse so a stale level never passes
		din_out = ~tx[0];
		#200;
	endtask : xfer
endmodule : ascd_host_model
`default_nettype wire

// ---- adc_serial_command_decoder_tb_top.sv ----
/* self-checking bench of the command decoder, host model on the serial pins.
   assumes a 200 MHz clock and the default id code of the decoder. */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder_tb_top;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic reg_mode = 1'b1;
	logic sclk, din, dout, rdy_n;
	ascd_pkg::ascd_conv_t conv = '0;
	ascd_pkg::ascd_cal_t cal = '0;
	ascd_pkg::ascd_ctrl_t ctrl;
	logic [10:0][7:0] regs, snap;
	logic [7:0] rx;
	logic [31:0] w;
	int num_errors = 0;
	int checked = 0;
	int restarts = 0;
	int ocal = 0;
	int gcal = 0;
	int cycles = 0;
	int r;

	always #2.5 clock_in = ~clock_in;

	ascd_host_model i_host (.sclk_out(sclk), .din_out(din), .dout_in(dout));
	ascd_decoder i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk),
		.din_in(din), .reg_mode_in(reg_mode), .dout_out(dout),
		.result_ready_n_out(rdy_n), .conv_in(conv), .cal_in(cal), .ctrl_out(ctrl),
		.regs_out(regs));

	// pulse counters; a long run means a hang
	always @(posedge clock_in) begin
		cycles++;
		if (ctrl.restart === 1'b1) restarts++;
		if (ctrl.offset_cal_start === 1'b1) ocal++;
		if (ctrl.gain_cal_start === 1'b1) gcal++;
		if (cycles == 60000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] b);
		i_host.xfer(b, rx);
	endtask : cmd

	task automatic pulse(input logic [31:0] d);
		@(negedge clock_in);
		conv.valid = 1'b1;
		conv.data = d;
		@(negedge clock_in);
		conv.valid = 1'b0;
		repeat (3) @(negedge clock_in);
	endtask : pulse

	// din low while reading doubles as a leave-standby in normal operation
	task automatic rd4();
		for (int i = 0; i < 4; i++) begin
			i_host.xfer(8'h00, rx);
			w = {w[23:0], rx};
		end
	endtask : rd4

	task automatic t_reads();
		pulse(32'hA5C30F81);
		chk("ready low", rdy_n, 0);
		rd4();
		chk("cont data", w, 32'hA5C30F81);
		chk("ready high", rdy_n, 1);
		cmd(8'h11);
		chk("cont off", ctrl.cont_mode, 0);
		pulse(32'h11111111);
		chk("ready held", rdy_n, 1);
		cmd(8'h12);
		pulse(32'h0F1E2D3C);
		chk("single ready", rdy_n, 0);
		rd4();
		chk("single data", w, 32'h0F1E2D3C);
	endtask : t_reads

	task automatic t_regs();
		r = restarts;
		cmd(8'h42);
		cmd(8'h01);
		cmd(8'hAA);
		cmd(8'hBB);
		chk("reg2", regs[2], 8'hAA);
		chk("reg3", regs[3], 8'hBB);
		chk("reg4", regs[4], 8'h03);
		chk("write restart", restarts, r + 1);
		cmd(8'h20);
		cmd(8'h03);
		rd4();
		chk("block read", w, 32'h5052AABB);
		cmd(8'h10);
		for (int i = 0; i < 63; i++) pulse(32'h22222222);
		chk("settle", rdy_n, 1);
		pulse(32'h33333333);
		chk("settled", rdy_n, 0);
		cmd(8'h11);
	endtask : t_regs

	task automatic t_ctrl();
		cmd(8'h03);
		chk("standby", ctrl.standby, 1);
		chk("regs kept", regs[3], 8'hBB);
		cmd(8'h01);
		chk("awake", ctrl.standby, 0);
		r = restarts;
		// single device here: its sync pin is taken as held high throughout
		cmd(8'h05);
		chk("sync", restarts, r + 1);
		cmd(8'h60);
		chk("ofs start", ocal, 1);
		@(negedge clock_in);
		cal = {1'b1, 24'h123456};
		@(negedge clock_in);
		cal.done = 1'b0;
		cmd(8'h61);
		chk("gain start", gcal, 1);
		@(negedge clock_in);
		cal = {1'b1, 24'h3ABCDE};
		@(negedge clock_in);
		cal.done = 1'b0;
		@(negedge clock_in);
		chk("offset", {regs[7], regs[6], regs[5]}, 24'h123456);
		chk("gain", {regs[10], regs[9], regs[8]}, 24'h3ABCDE);
		snap = regs;
		cmd(8'h13);
		cmd(8'h7F);
		chk("undef regs", regs, snap);
		chk("undef mode", ctrl.cont_mode, 0);
		@(negedge clock_in);
		reg_mode = 1'b0;
		repeat (4) @(negedge clock_in);
		cmd(8'h02);
		chk("pin mode", ctrl.standby, 0);
		reg_mode = 1'b1;
		repeat (4) @(negedge clock_in);
		r = restarts;
		cmd(8'h07);
		chk("reset regs", regs[10:1], ascd_pkg::REG_RESET[10:1]);
		chk("reset cont", ctrl.cont_mode, 1);
		chk("reset restart", restarts, r + 1);
		chk("gap flag", ctrl.gap_error, 0);
	endtask : t_ctrl

	// register write: start byte, count minus one, then the low bytes of d first
	task automatic register_write_cmd(input logic [4:0] a, input logic [7:0] n, input logic [47:0] d);
		cmd({3'h2, a});
		cmd(n - 8'h01);
		for (int i = 0; i < n; i++) cmd(d[8*i +: 8]);
	endtask : register_write_cmd

	// a register write drops the next 63 readings
	task automatic settle63();
		for (int i = 0; i < 63; i++) pulse(32'h22222222);
	endtask : settle63

	task automatic rdata(input logic [31:0] d);
		cmd(8'h12);
		pulse(d);
		chk("ucal ready", rdy_n, 0);
		rd4();
		chk("ucal reading", w, d);
	endtask : rdata

	// host-side calibration: neutral corrections, then measured offset and gain
	task automatic t_user_cal();
		longint sum;
		logic [23:0] ofs;
		logic [23:0] gain;
		cmd(8'h11);
		register_write_cmd(5'h05, 8'h06, 48'h400000000000);
		chk("ucal ofs zero", {regs[7], regs[6], regs[5]}, 24'h000000);
		chk("ucal gain one", {regs[10], regs[9], regs[8]}, 24'h400000);
		settle63();
		sum = 0;
		for (int i = 0; i < 4; i++) begin
			rdata(32'h00001000 + 32'h00000200 * i);
			sum += w;
		end
		// offset is left-justified against the 32-bit result
		ofs = 24'(sum / 4 >> 8);
		register_write_cmd(5'h05, 8'h03, {24'h000000, ofs});
		chk("ucal ofs", {regs[7], regs[6], regs[5]}, 24'h000013);
		settle63();
		sum = 0;
		for (int i = 0; i < 2; i++) begin
			rdata(32'h3E000000);
			sum += w;
		end
		// expected full-scale code 3C000000h on the 32-bit output scale
		gain = 24'(64'h0000000000400000 * 64'h000000003C000000 / (sum / 2));
		register_write_cmd(5'h08, 8'h03, {24'h000000, gain});
		chk("ucal gain", {regs[10], regs[9], regs[8]}, 24'h3DEF7B);
	endtask : t_user_cal

	initial begin
		repeat (5) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (3) @(negedge clock_in);
		chk("rst regs", regs[10:1], ascd_pkg::REG_RESET[10:1]);
		chk("rst cont", ctrl.cont_mode, 1);
		chk("rst ready", rdy_n, 1);
		t_reads();
		t_regs();
		t_ctrl();
		t_user_cal();
		end_sim();
	end
endmodule : adc_serial_command_decoder_tb_top
`default_nettype wire
